// *** frc_map.svh ***
`ifndef FRC_MAP_SVH
`define FRC_MAP_SVH
// Timing figures in ns at the 3.0V-5.5V grade, clock period in ns
`define FRC_CLK_PERIOD_NS      4
`define FRC_ACCESS_TIME_NS     70
`define FRC_CE_ACTIVE_NS       70
`define FRC_PRECHARGE_NS       60
`define FRC_ADDR_HOLD_NS       15
`define FRC_OE_HIZ_NS          15
// Least times round up to whole cycles
`define FRC_CEIL_CYC(ns)       (((ns) + `FRC_CLK_PERIOD_NS - 1) / `FRC_CLK_PERIOD_NS)
`define FRC_ACCESS_CYC         `FRC_CEIL_CYC(`FRC_ACCESS_TIME_NS)
`define FRC_CE_ACTIVE_CYC      `FRC_CEIL_CYC(`FRC_CE_ACTIVE_NS)
`define FRC_PRECHARGE_CYC      `FRC_CEIL_CYC(`FRC_PRECHARGE_NS)
`define FRC_ADDR_HOLD_CYC      `FRC_CEIL_CYC(`FRC_ADDR_HOLD_NS)
`define FRC_OE_HIZ_CYC         `FRC_CEIL_CYC(`FRC_OE_HIZ_NS)
`define FRC_ADDR_W             13
`define FRC_DATA_W             8
`define FRC_ROW_LSB            3
`endif

// *** frc_pkg.sv ***
package frc_pkg;
  typedef enum logic [2:0] {
    FRC_IDLE,
    FRC_SETUP,
    FRC_ACTIVE,
    FRC_RELEASE,
    FRC_PRECHARGE
  } frc_state_type;
endpackage

// *** frc_sync.sv ***
`timescale 1ns/100ps
module frc_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_ff;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_ff <= '0;
      sync_o  <= '0;
    end else begin
      meta_ff <= async_i;
      sync_o  <= meta_ff;
    end
  end
endmodule

// *** frc_host.sv ***
`timescale 1ns/100ps
`include "frc_map.svh"
// Notes on behaviour
// - Host holds write data stable through setup before write end.
// - Host raises chip select and holds it high for precharge time.
// - Host keeps chip select low no longer than the maximum.
// - Host makes a fresh chip select falling edge for every access.
// - Host holds chip select high while supply is below 2.7V.
module frc_host
  import frc_pkg::*;
#(
  parameter int ADDR_W        = `FRC_ADDR_W,
  parameter int DATA_W        = `FRC_DATA_W,
  parameter int ACCESS_CYC    = `FRC_ACCESS_CYC,
  parameter int ACTIVE_CYC    = `FRC_CE_ACTIVE_CYC,
  parameter int PRECHARGE_CYC = `FRC_PRECHARGE_CYC,
  parameter int HOLD_CYC      = `FRC_ADDR_HOLD_CYC,
  parameter int HIZ_CYC       = `FRC_OE_HIZ_CYC
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Request side
  input  wire logic              req_valid_i,
  input  wire logic              req_write_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic [DATA_W-1:0] req_wdata_i,
  input  wire logic              supply_ok_i,
  output logic                   req_ready_o,
  output logic                   rsp_valid_o,
  output logic [DATA_W-1:0]      rsp_rdata_o,
  output logic [ADDR_W-4:0]      rsp_row_o,
  // Memory pins
  output logic                   mem_ce_n_o,
  output logic                   mem_ce_oe_n_o,
  output logic                   mem_oe_n_o,
  output logic                   mem_we_n_o,
  output logic [ADDR_W-1:0]      mem_addr_o,
  output logic [DATA_W-1:0]      mem_dq_o,
  output logic                   mem_dq_oe_n_o,
  input  wire logic [DATA_W-1:0] mem_dq_i
);
  localparam int CNT_W = 8;
  // Read wait: access time plus one for output enable settling, plus two sync stages
  localparam int READ_CYC = (ACCESS_CYC > ACTIVE_CYC ? ACCESS_CYC : ACTIVE_CYC) + 3;

  frc_state_type     state_ff;
  frc_state_type     nxt_state;
  logic [CNT_W-1:0]  cnt_ff;
  logic [CNT_W-1:0]  nxt_cnt;
  logic              write_ff;
  logic [DATA_W-1:0] dq_sync;
  logic              supply_ok_ff;

  frc_sync #(
    .WIDTH (DATA_W)
  ) u_dq_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (mem_dq_i),
    .sync_o  (dq_sync)
  );

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n);
  endfunction

  wire cnt_done   = (cnt_ff == '0);
  wire start_ok   = req_valid_i && supply_ok_ff;
  wire access_end = (state_ff == FRC_ACTIVE) && cnt_done;
  // In idle the kind is not yet latched, so strobe set-up must read the request itself
  wire wr_sel     = (state_ff == FRC_IDLE) ? req_write_i : write_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_done ? cnt_ff : cnt_ff - cyc(1);
    case (state_ff)
      FRC_IDLE: begin
        if (start_ok) begin
          nxt_state = FRC_SETUP;
        end
      end
      // One cycle of address and strobe set-up before chip select falls
      FRC_SETUP: begin
        nxt_state = FRC_ACTIVE;
        nxt_cnt   = write_ff ? cyc(ACTIVE_CYC) : cyc(READ_CYC);
      end
      FRC_ACTIVE: begin
        if (cnt_done) begin
          nxt_state = FRC_RELEASE;
          nxt_cnt   = cyc(HOLD_CYC > HIZ_CYC ? HOLD_CYC : HIZ_CYC);
        end
      end
      // Address hold and bus turnaround before the next access
      FRC_RELEASE: begin
        if (cnt_done) begin
          nxt_state = FRC_PRECHARGE;
        end
      end
      FRC_PRECHARGE: begin
        if (cnt_done) begin
          nxt_state = FRC_IDLE;
        end
      end
      default: begin
        nxt_state = FRC_IDLE;
      end
    endcase
    if (state_ff == FRC_ACTIVE && cnt_done) begin
      // Precharge counted from the chip select rise, includes the release wait
      nxt_cnt = cyc(PRECHARGE_CYC - 1);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff     <= FRC_IDLE;
      cnt_ff       <= '0;
      supply_ok_ff <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      cnt_ff       <= nxt_cnt;
      supply_ok_ff <= supply_ok_i;
    end
  end

  // Request capture; ready only in idle so each access gets its own chip select fall
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      write_ff    <= 1'b0;
      mem_addr_o  <= '0;
      mem_dq_o    <= '0;
      req_ready_o <= 1'b0;
    end else begin
      req_ready_o <= (nxt_state == FRC_IDLE) && supply_ok_i;
      if (state_ff == FRC_IDLE && start_ok) begin
        write_ff   <= req_write_i;
        mem_addr_o <= req_addr_i;
        mem_dq_o   <= req_wdata_i;
      end
    end
  end

  // Pin drive; chip select released to the pull-up while supply is not good
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_ce_n_o    <= 1'b1;
      mem_ce_oe_n_o <= 1'b1;
      mem_oe_n_o    <= 1'b1;
      mem_we_n_o    <= 1'b1;
      mem_dq_oe_n_o <= 1'b1;
    end else begin
      mem_ce_oe_n_o <= !supply_ok_ff;
      // Chip select low only in the active window, bounded by the counter
      mem_ce_n_o    <= !(nxt_state == FRC_ACTIVE);
      // Strobe set low before chip select falls: chip-select-controlled write
      mem_we_n_o    <= !(wr_sel && (nxt_state == FRC_SETUP || nxt_state == FRC_ACTIVE));
      mem_oe_n_o    <= !(!write_ff && nxt_state == FRC_ACTIVE);
      mem_dq_oe_n_o <= !(wr_sel && (nxt_state == FRC_SETUP || nxt_state == FRC_ACTIVE));
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= '0;
      rsp_row_o   <= '0;
    end else begin
      // Write is done at chip select rise; no polling needed
      rsp_valid_o <= access_end;
      if (access_end) begin
        rsp_row_o <= mem_addr_o[ADDR_W-1:`FRC_ROW_LSB];
        if (!write_ff) begin
          rsp_rdata_o <= dq_sync;
        end
      end
    end
  end
endmodule

// *** frc_mem_model.sv ***
`timescale 1ns/100ps
module frc_mem_model (
  // Memory pins
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic [12:0] addr_i,
  input  wire logic [7:0]  host_dq_i,
  input  wire logic        host_oe_n_i,
  output logic      [7:0]  dq_o
);
  logic [7:0]  mem [0:8191];
  logic [12:0] a_ff;
  logic        wr_ff = 1'b0;
  logic        rdy_ff = 1'b0;
  logic        drv;
  always @(negedge ce_n_i) begin
    a_ff = addr_i;
    wr_ff = !we_n_i;
    rdy_ff = 1'b0;
    #70 rdy_ff = 1'b1;
  end
  always @(negedge we_n_i) if (!ce_n_i) wr_ff = 1'b1;
  always @(posedge ce_n_i or posedge we_n_i) if (wr_ff) begin
    mem[a_ff] = host_dq_i;
    wr_ff = 1'b0;
  end
  assign drv = !oe_n_i && !ce_n_i && !wr_ff && rdy_ff;
  // Released bus shows the inverse, so a stale value cannot pass
  assign dq_o = drv ? mem[a_ff] : (host_oe_n_i ? ~host_dq_i : host_dq_i);
endmodule

// *** frc_host_asserts.sv ***
`timescale 1ns/100ps
module frc_host_asserts (
  // Watched ports
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       req_valid_i,
  input  wire logic       supply_ok_i,
  input  wire logic       req_ready_o,
  input  wire logic       mem_ce_n_o,
  input  wire logic       mem_we_n_o,
  input  wire logic       mem_oe_n_o,
  input  wire logic       mem_dq_oe_n_o,
  input  wire logic [7:0] mem_dq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence ce_hi7;
    mem_ce_n_o [*7];
  endsequence
  pchg_min_a: assert property ($rose(mem_ce_n_o) |=> ce_hi7 ##1 ce_hi7) else $error("short precharge");
  wdata_hold_a: assert property (!mem_we_n_o && !mem_ce_n_o |-> !mem_dq_oe_n_o && $stable(mem_dq_o))
    else $error("write data moved");
  ce_low_max_a: assert property ($fell(mem_ce_n_o) |-> ##[1:30] mem_ce_n_o) else $error("ce low too long");
  fresh_ce_a: assert property (req_valid_i && req_ready_o |-> ##[1:3] $fell(mem_ce_n_o))
    else $error("no ce fall for access");
  supply_gate_a: assert property (!supply_ok_i [*3] |-> !req_ready_o) else $error("ready without supply");
  oe_read_only_a: assert property (!mem_oe_n_o |-> mem_we_n_o && !mem_ce_n_o)
    else $error("output enable outside read");
  we_setup_a: assert property ($fell(mem_ce_n_o) && !mem_we_n_o |-> $past(!mem_we_n_o))
    else $error("strobe not set up before chip select");
endmodule
bind frc_host frc_host_asserts u_frc_host_asserts (.*);

// *** tb.sv ***
`timescale 1ns/100ps
module tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        req_valid_i = 1'b0;
  logic        req_write_i = 1'b0;
  logic        supply_ok_i = 1'b1;
  logic [12:0] req_addr_i = 13'h0000;
  logic [7:0]  req_wdata_i = 8'h00;
  logic        req_ready_o, rsp_valid_o, mem_ce_n_o, mem_ce_oe_n_o, mem_oe_n_o, mem_we_n_o, mem_dq_oe_n_o;
  logic [7:0]  rsp_rdata_o, mem_dq_o, mem_dq_i;
  logic [9:0]  rsp_row_o;
  logic [12:0] mem_addr_o;
  int          fail_count = 0;
  int          checked = 0;
  always #2 clk_i = ~clk_i;
  frc_host u_frc_host (.*);
  frc_mem_model u_frc_mem_model (.ce_n_i(mem_ce_oe_n_o ? 1'b1 : mem_ce_n_o), .oe_n_i(mem_oe_n_o),
    .we_n_i(mem_we_n_o), .addr_i(mem_addr_o), .host_dq_i(mem_dq_o), .host_oe_n_i(mem_dq_oe_n_o), .dq_o(mem_dq_i));
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [12:0] a, input logic [7:0] d);
    int n;
    req_write_i <= w;
    req_addr_i <= a;
    req_wdata_i <= d;
    req_valid_i <= 1'b1;
    n = 0;
    do @(posedge clk_i); while (req_ready_o !== 1'b1 && ++n < 200);
    if (n >= 200) fail_count++;
    req_valid_i <= 1'b0;
    n = 0;
    do @(posedge clk_i); while (rsp_valid_o !== 1'b1 && ++n < 60);
    if (n >= 60) fail_count++;
    chk(rsp_row_o, a[12:3]);
  endtask
  task automatic t_rw;
    acc(1'b1, 13'h0007, 8'hA5);
    acc(1'b1, 13'h0008, 8'h5A);
    acc(1'b1, 13'h1FFF, 8'hC3);
    acc(1'b0, 13'h0007, 8'h00);
    chk({2'h0, rsp_rdata_o}, 10'h0A5);
    acc(1'b0, 13'h0008, 8'h00);
    chk({2'h0, rsp_rdata_o}, 10'h05A);
  endtask
  task automatic t_supply;
    int seen;
    seen = 0;
    supply_ok_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    req_valid_i <= 1'b1;
    repeat (40) begin
      @(posedge clk_i);
      if (rsp_valid_o === 1'b1 || req_ready_o === 1'b1) seen++;
    end
    chk(seen[9:0], 10'h000);
    supply_ok_i <= 1'b1;
    acc(1'b0, 13'h1FFF, 8'h00);
    chk({2'h0, rsp_rdata_o}, 10'h0C3);
  endtask
  task automatic give_verdict;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_rw();
    t_supply();
    give_verdict();
  end
  // About twenty times the expected run
  initial begin
    #20000;
    fail_count++;
    give_verdict();
  end
endmodule
